// ===== tx_link_consts.svh
// Offsets, field positions, reset values and fixed sizes of the transmit link.
// Assumes inclusion by bare name from every file that needs a number.
`ifndef TX_LINK_CONSTS_SVH
`define TX_LINK_CONSTS_SVH
// ========================================
// Register offsets
`define OFF_LINK_CFG 8'h0d
`define OFF_TX_CTRL 8'h34
`define OFF_TX_UPPER 8'h35
`define OFF_TX_LOWER 8'h36
`define OFF_TX_IEN 8'h37
`define OFF_TX_STAT 8'h38
`define OFF_TX_DATA 8'h39
`define OFF_L2_POS 8'h70
`define OFF_L2_MASK 8'h71
// ========================================
// Field positions
`define CFG_PATH 3
`define CFG_SEL_LO 4
`define CFG_SEL_HI 5
`define CFG_ACCESS 6
`define CTRL_EN 0
`define CTRL_CRC 1
`define CTRL_EOM 3
`define CTRL_CLR 6
`define POS_EVEN 7
`define POS_ODD 6
`define POS_TS_HI 4
`define IEN_FULL 3
`define IEN_OVR 2
`define IEN_UDR 1
`define IEN_LOW 0
// ========================================
// Codes and reset values
`define SEL_LINK1 2'h0
`define SEL_LINK2 2'h1
`define RST_REG 8'h00
`define RST_UPPER 8'h0c
`define RST_LOWER 8'h04
`define RST_MASK 8'hff
`define FLAG_BYTE 8'h7e
`define ABORT_BYTE 8'hff
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h8408
`define STUFF_RUN 3'h5
`define FIFO_DEPTH 16
`endif

// ===== tx_link_pkg.sv
// Types shared by the transmit link controller, the framer model and the bench.
// Assumes nothing beyond a SystemVerilog compiler.
package tx_link_pkg;
  // ========================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic strobe;
    logic fbit;
    logic odd;
    logic [4:0] ts;
    logic [2:0] bitpos;
  } frame_slot_t;

  typedef struct packed {
    logic end_of_message;
    logic [7:0] data;
  } fifo_word_t;

  typedef enum logic [1:0] {S_FLAG, S_DATA, S_FCS, S_ABORT} tx_state_t;
endpackage : tx_link_pkg

// ===== link_fifo.sv
// Synchronous FIFO with valid and ready on both sides and a fill level.
// Assumes one clock; clear empties it on the next edge.
module link_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic clear,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic push;
  logic pop;

  assign in_ready = level != FULL_CNT;
  assign out_valid = level != '0;
  assign out_data = mem[rp];
  assign push = in_valid && in_ready && !clear;
  assign pop = out_valid && out_ready && !clear;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wp <= '0;
      rp <= '0;
      level <= '0;
    end else if (clear) begin
      wp <= '0;
      rp <= '0;
      level <= '0;
    end else begin
      wp <= push ? wp + 1'b1 : wp;
      rp <= pop ? rp + 1'b1 : rp;
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge mclk) disable iff (reset)
    push && !pop |=> level == $past(level) + 1'b1)
    else $error("FIFO level did not follow a push");
endmodule : link_fifo

// ===== fcs_gen.sv
// Bit-serial frame check sequence, reflected CCITT polynomial, least bit first.
// Assumes init and en are never both used to change the sum in one cycle.
`include "tx_link_consts.svh"
module fcs_gen (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Data
  input wire logic init,
  input wire logic en,
  input wire logic din,
  output logic [15:0] crc,
  output logic [15:0] crc_next
);
  always_comb begin
    crc_next = {1'b0, crc[15:1]} ^ ((crc[0] ^ din) ? `CRC_POLY : 16'h0000);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      crc <= `CRC_INIT;
    end else if (init) begin
      crc <= `CRC_INIT;
    end else if (en) begin
      crc <= crc_next;
    end
  end
endmodule : fcs_gen

// ===== tx_link_controller.sv
// Transmit data link controller: registers, byte staging, FIFO, bit framer.
// Assumes the CPU request and frame slot timing are synchronous to mclk.
//
// What this block does
// - Two-bit select field picks active link.
// - First link uses odd-frame framing bits only.
// - Second link: even/odd frames, chosen timeslot.
// - Bit mask picks channel bits carrying data.
// - Link runs only while enable bit set.
// - Clear bit initialises FIFO; host pulses it.
// - Check bit appends frame check sequence.
// - Four enables gate events onto interrupt.
// - Send on end-of-message or upper threshold.
// - Data bytes enter FIFO in write order.
// - C3H then 83H: enabled, checked, cleared.
// - 8BH marks end keeping control bits.
// - 58H selects second link on transmit path.
`include "tx_link_consts.svh"
module tx_link_controller (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // CPU register port
  input tx_link_pkg::cpu_req_t cpu_req,
  output logic [7:0] cpu_rdata,
  // Frame slot timing from the framer
  input tx_link_pkg::frame_slot_t slot,
  // Serial link output
  output logic link_insert,
  output logic link_bit,
  // Status
  output logic irq_n,
  output logic tx_fifo_full
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);

  // ========================================
  // Register file
  logic [7:0] link_cfg;
  logic [7:0] tx_ctrl;
  logic [7:0] upper_thr;
  logic [7:0] lower_thr;
  logic [7:0] irq_en;
  logic [7:0] l2_pos;
  logic [7:0] l2_mask;
  logic overrun;
  logic underrun;
  logic [7:0] stat;
  logic [1:0] sel;
  logic data_wr;
  logic eom_wr;
  logic ctrl_wr;

  assign ctrl_wr = cpu_req.wr && cpu_req.addr == `OFF_TX_CTRL;
  assign data_wr = cpu_req.wr && cpu_req.addr == `OFF_TX_DATA;
  assign eom_wr = ctrl_wr && cpu_req.wdata[`CTRL_EOM];
  assign sel = link_cfg[`CFG_SEL_HI:`CFG_SEL_LO];

  // The end-of-message bit acts on the write and is not stored, so that
  // rewriting the control register later cannot close a second packet.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      link_cfg <= `RST_REG;
      tx_ctrl <= `RST_REG;
      upper_thr <= `RST_UPPER;
      lower_thr <= `RST_LOWER;
      irq_en <= `RST_REG;
      l2_pos <= `RST_REG;
      l2_mask <= `RST_MASK;
    end else if (cpu_req.wr) begin
      case (cpu_req.addr)
        `OFF_LINK_CFG: link_cfg <= cpu_req.wdata;
        `OFF_TX_CTRL: tx_ctrl <= cpu_req.wdata & ~(8'h01 << `CTRL_EOM);
        `OFF_TX_UPPER: upper_thr <= cpu_req.wdata;
        `OFF_TX_LOWER: lower_thr <= cpu_req.wdata;
        `OFF_TX_IEN: irq_en <= cpu_req.wdata;
        `OFF_L2_POS: l2_pos <= cpu_req.wdata;
        `OFF_L2_MASK: l2_mask <= cpu_req.wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_req.rd) begin
      case (cpu_req.addr)
        `OFF_LINK_CFG: cpu_rdata <= link_cfg;
        `OFF_TX_CTRL: cpu_rdata <= tx_ctrl;
        `OFF_TX_UPPER: cpu_rdata <= upper_thr;
        `OFF_TX_LOWER: cpu_rdata <= lower_thr;
        `OFF_TX_IEN: cpu_rdata <= irq_en;
        `OFF_TX_STAT: cpu_rdata <= stat;
        `OFF_L2_POS: cpu_rdata <= l2_pos;
        `OFF_L2_MASK: cpu_rdata <= l2_mask;
        default: cpu_rdata <= 8'h00;
      endcase
    end
  end

  // ========================================
  // Byte staging and FIFO
  // The newest byte waits in a staging register so that a later end mark
  // can be attached to it; the FIFO therefore lags the writes by one byte.
  logic [7:0] stage_byte;
  logic stage_valid;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  tx_link_pkg::fifo_word_t fifo_in;
  tx_link_pkg::fifo_word_t fifo_out;
  logic [4:0] fifo_level;
  logic [4:0] pkt_count;
  logic clr;
  logic go;
  logic overrun_set;

  assign clr = tx_ctrl[`CTRL_CLR];
  assign fifo_in_valid = stage_valid && (data_wr || eom_wr);
  assign fifo_in = '{end_of_message: eom_wr, data: stage_byte};
  assign overrun_set = fifo_in_valid && !fifo_in_ready && !clr;
  assign go = pkt_count != 5'h00 || {3'h0, fifo_level} >= upper_thr;

  link_fifo #(
    .WIDTH(9),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .clear(clr),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stage_valid <= 1'b0;
      stage_byte <= 8'h00;
    end else if (clr) begin
      stage_valid <= 1'b0;
    end else if (data_wr && (!stage_valid || fifo_in_ready)) begin
      stage_byte <= cpu_req.wdata;
      stage_valid <= 1'b1;
    end else if (eom_wr && fifo_in_ready) begin
      stage_valid <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pkt_count <= 5'h00;
    end else if (clr) begin
      pkt_count <= 5'h00;
    end else begin
      pkt_count <= pkt_count + 5'(fifo_in_valid && fifo_in_ready && eom_wr)
                   - 5'(fifo_pop && fifo_out.end_of_message);
    end
  end

  // ========================================
  // Slot selection
  logic take;
  logic hit1;
  logic hit2;

  assign hit1 = sel == `SEL_LINK1 && slot.fbit && slot.odd;
  assign hit2 = sel == `SEL_LINK2 && link_cfg[`CFG_PATH] && !slot.fbit
                && slot.ts == l2_pos[`POS_TS_HI:0]
                && (slot.odd ? l2_pos[`POS_ODD] : l2_pos[`POS_EVEN])
                && l2_mask[slot.bitpos];
  assign take = slot.strobe && tx_ctrl[`CTRL_EN] && (hit1 || hit2);

  // ========================================
  // Bit framer
  tx_link_pkg::tx_state_t state;
  tx_link_pkg::tx_state_t next_state;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic [2:0] cnt;
  logic [2:0] ones;
  logic stuff_cur;
  logic next_stuff;
  logic skip;
  logic next_skip;
  logic last_byte;
  logic fcs_phase;
  logic [7:0] fcs_hi;
  logic stuff_now;
  logic cur_bit;
  logic byte_end;
  logic crc_en;
  logic underrun_set;
  logic [15:0] crc;
  logic [15:0] crc_next;

  assign stuff_now = ones == `STUFF_RUN;
  assign cur_bit = stuff_now ? 1'b0 : sh[0];
  assign byte_end = take && !stuff_now && cnt == 3'h7;
  assign crc_en = take && !stuff_now && state == tx_link_pkg::S_DATA;

  fcs_gen u_fcs (
    .mclk(mclk),
    .reset(reset),
    .init(state == tx_link_pkg::S_FLAG),
    .en(crc_en),
    .din(sh[0]),
    .crc(crc),
    .crc_next(crc_next)
  );

  always_comb begin
    next_state = state;
    next_sh = {1'b0, sh[7:1]};
    next_stuff = stuff_cur;
    next_skip = skip;
    fifo_pop = 1'b0;
    underrun_set = 1'b0;
    if (byte_end) begin
      case (state)
        tx_link_pkg::S_FLAG: begin
          next_sh = `FLAG_BYTE;
          next_stuff = 1'b0;
          if (skip && fifo_out_valid) begin
            fifo_pop = 1'b1;
            next_skip = !fifo_out.end_of_message;
          end else if (!skip && go && fifo_out_valid) begin
            fifo_pop = 1'b1;
            next_sh = fifo_out.data;
            next_stuff = 1'b1;
            next_state = tx_link_pkg::S_DATA;
          end
        end
        tx_link_pkg::S_DATA: begin
          if (last_byte && tx_ctrl[`CTRL_CRC]) begin
            next_sh = ~crc_next[7:0];
            next_state = tx_link_pkg::S_FCS;
          end else if (last_byte) begin
            next_sh = `FLAG_BYTE;
            next_stuff = 1'b0;
            next_state = tx_link_pkg::S_FLAG;
          end else if (fifo_out_valid) begin
            fifo_pop = 1'b1;
            next_sh = fifo_out.data;
          end else begin
            next_sh = `ABORT_BYTE;
            next_stuff = 1'b0;
            next_skip = 1'b1;
            underrun_set = 1'b1;
            next_state = tx_link_pkg::S_ABORT;
          end
        end
        tx_link_pkg::S_FCS: begin
          if (!fcs_phase) begin
            next_sh = fcs_hi;
          end else begin
            next_sh = `FLAG_BYTE;
            next_stuff = 1'b0;
            next_state = tx_link_pkg::S_FLAG;
          end
        end
        tx_link_pkg::S_ABORT: begin
          next_sh = `FLAG_BYTE;
          next_state = tx_link_pkg::S_FLAG;
        end
        default: begin
          next_state = tx_link_pkg::S_FLAG;
        end
      endcase
    end
  end

  // A disabled link falls back to idle flags; a skip in progress survives unless
  // the clear bit is set, so that the rest of an aborted packet is still discarded.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= tx_link_pkg::S_FLAG;
      sh <= `FLAG_BYTE;
      cnt <= 3'h0;
      ones <= 3'h0;
      stuff_cur <= 1'b0;
      skip <= 1'b0;
      last_byte <= 1'b0;
      fcs_phase <= 1'b0;
      fcs_hi <= 8'h00;
    end else if (!tx_ctrl[`CTRL_EN] || clr) begin
      state <= tx_link_pkg::S_FLAG;
      sh <= `FLAG_BYTE;
      cnt <= 3'h0;
      ones <= 3'h0;
      stuff_cur <= 1'b0;
      skip <= clr ? 1'b0 : skip;
    end else if (take) begin
      if (stuff_now) begin
        ones <= 3'h0;
      end else begin
        ones <= (stuff_cur && sh[0]) ? ones + 3'h1 : 3'h0;
        cnt <= cnt + 3'h1;
        sh <= next_sh;
      end
      state <= next_state;
      stuff_cur <= next_stuff;
      skip <= next_skip;
      if (fifo_pop) begin
        last_byte <= fifo_out.end_of_message;
      end
      if (byte_end && state == tx_link_pkg::S_DATA) begin
        fcs_hi <= ~crc_next[15:8];
        fcs_phase <= 1'b0;
      end else if (byte_end && state == tx_link_pkg::S_FCS) begin
        fcs_phase <= 1'b1;
      end
    end
  end

  // ========================================
  // Events and outputs
  // Overrun and underrun stay set until the status register is read;
  // an event in the read cycle wins over the clear.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      overrun <= 1'b0;
      underrun <= 1'b0;
    end else begin
      overrun <= overrun_set || (overrun && !(cpu_req.rd && cpu_req.addr == `OFF_TX_STAT));
      underrun <= underrun_set || (underrun && !(cpu_req.rd && cpu_req.addr == `OFF_TX_STAT));
    end
  end

  assign stat = {4'h0, !fifo_in_ready, overrun, underrun, {3'h0, fifo_level} < lower_thr};

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      link_insert <= 1'b0;
      link_bit <= 1'b1;
      irq_n <= 1'b1;
      tx_fifo_full <= 1'b0;
    end else begin
      link_insert <= take;
      link_bit <= take ? cur_bit : 1'b1;
      irq_n <= ~|(stat[3:0] & irq_en[3:0]);
      tx_fifo_full <= !fifo_in_ready;
    end
  end

  // ========================================
  // Checks
  link_off_a: assert property (!tx_ctrl[`CTRL_EN] |=> !link_insert)
    else $error("Link inserted while disabled");
  link1_pos_a: assert property ($past(sel) == `SEL_LINK1 && link_insert
    |-> $past(slot.fbit && slot.odd))
    else $error("First link used a wrong position");
  link2_pos_a: assert property ($past(sel) == `SEL_LINK2 && link_insert
    |-> $past(slot.ts == l2_pos[4:0] && l2_mask[slot.bitpos] && !slot.fbit))
    else $error("Second link used a wrong slot or bit");
  bad_sel_a: assert property (sel[1] |=> !link_insert)
    else $error("Link inserted with no link selected");
  fifo_clear_a: assert property (clr |=> fifo_level == 5'h00 && !stage_valid)
    else $error("FIFO not emptied by clear");
  fcs_gate_a: assert property (state == tx_link_pkg::S_FCS
    && $past(state) != tx_link_pkg::S_FCS |-> $past(tx_ctrl[`CTRL_CRC]))
    else $error("Check sequence sent while disabled");
  start_cause_a: assert property (state == tx_link_pkg::S_DATA
    && $past(state) == tx_link_pkg::S_FLAG |-> $past(go))
    else $error("Packet started without a cause");
  stuff_zero_a: assert property (take && stuff_now |=> link_insert && !link_bit)
    else $error("Stuffed bit was not a zero");
  abort_flag_a: assert property (state == tx_link_pkg::S_ABORT
    && $past(state) == tx_link_pkg::S_DATA |-> underrun && skip)
    else $error("Abort without underrun");
  irq_map_a: assert property (overrun && irq_en[`IEN_OVR] |=> !irq_n)
    else $error("Enabled overrun did not raise the interrupt");
  push_order_a: assert property (data_wr && stage_valid && fifo_in_ready && !clr
    |=> stage_byte == $past(cpu_req.wdata))
    else $error("Written byte not staged in order");
endmodule : tx_link_controller

// ===== framer_model.sv
// Framer-side partner: makes the frame slot timing and decodes inserted link bits.
// Assumes one slot strobe per mclk, one framing bit then 24 channels of 8 bits.
module framer_model (
  // Clock
  input wire logic mclk,
  // Expected insertion place
  input wire logic want_link1,
  input wire logic [4:0] want_ts,
  // Slot timing to the controller
  output tx_link_pkg::frame_slot_t slot,
  // Serial link from the controller
  input wire logic link_insert,
  input wire logic link_bit
);
  int idx = 0;
  int ones = 0;
  int bad_pos = 0;
  int n_ins = 0;
  logic [7:0] rx[$];
  logic dq[$];
  tx_link_pkg::frame_slot_t last = '0;
  initial slot = '0;

  // ========================================
  // Slot timing
  always @(posedge mclk) begin
    #1;
    slot.strobe = 1'b1;
    slot.fbit = (idx == 0);
    slot.ts = 5'((idx - 1) / 8);
    slot.bitpos = 3'((idx - 1) % 8);
    if (idx == 0) slot.odd = ~slot.odd;
    idx = (idx == 192) ? 0 : idx + 1;
  end

  // ========================================
  // Bit decoder
  // Only the first whole frame is kept, so a later aborted packet cannot hide it.
  task automatic take_bit(input logic b);
    logic [7:0] v;
    if (b) begin
      ones++;
      dq.push_back(b);
      if (ones == 7) dq.delete();
    end else if (ones == 5) begin
      ones = 0;
    end else if (ones == 6) begin
      ones = 0;
      repeat (7) if (dq.size() > 0) void'(dq.pop_back());
      if (dq.size() >= 16 && dq.size() % 8 == 0 && rx.size() == 0) begin
        for (int i = 0; i < dq.size() / 8; i++) begin
          for (int j = 0; j < 8; j++) v[j] = dq[8 * i + j];
          rx.push_back(v);
        end
      end
      dq.delete();
    end else begin
      ones = 0;
      dq.push_back(b);
    end
  endtask : take_bit

  always @(posedge mclk) begin
    if (link_insert === 1'b1) begin
      n_ins++;
      if (want_link1 ? !(last.fbit && last.odd) : (last.fbit || last.ts != want_ts))
        bad_pos++;
      take_bit(link_bit);
    end
    last = slot;
  end
endmodule : framer_model

// ===== hdlc_datalink_transmitter_bench.sv
// Self-checking bench for the transmit link controller.
// Assumes the framer model supplies slot timing and decodes the link.
module hdlc_datalink_transmitter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  tx_link_pkg::cpu_req_t cpu_req = '0;
  tx_link_pkg::frame_slot_t slot;
  logic [7:0] cpu_rdata;
  logic link_insert;
  logic link_bit;
  logic irq_n;
  logic tx_fifo_full;
  logic want_link1 = 1'b0;
  logic [4:0] want_ts = 5'h04;
  logic [7:0] got;
  logic [15:0] crc;
  int n_errors = 0;
  int tests_run = 0;
  int k;
  int n0;
  logic [7:0] pkt [8] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc, 8'hde, 8'hff};
  row_t rows [20] = '{
    '{1'b0, 8'h0d, 8'h00, 8'h00}, '{1'b0, 8'h34, 8'h00, 8'h00},
    '{1'b0, 8'h35, 8'h00, 8'h0c}, '{1'b0, 8'h36, 8'h00, 8'h04},
    '{1'b0, 8'h37, 8'h00, 8'h00}, '{1'b0, 8'h38, 8'h00, 8'h01},
    '{1'b0, 8'h39, 8'h00, 8'h00}, '{1'b0, 8'h70, 8'h00, 8'h00},
    '{1'b0, 8'h71, 8'h00, 8'hff}, '{1'b0, 8'h50, 8'h00, 8'h00},
    '{1'b1, 8'h0d, 8'h58, 8'h00}, '{1'b0, 8'h0d, 8'h00, 8'h58},
    '{1'b1, 8'h70, 8'hc4, 8'h00}, '{1'b0, 8'h70, 8'h00, 8'hc4},
    '{1'b1, 8'h71, 8'hff, 8'h00}, '{1'b0, 8'h71, 8'h00, 8'hff},
    '{1'b1, 8'h37, 8'h0f, 8'h00}, '{1'b0, 8'h37, 8'h00, 8'h0f},
    '{1'b1, 8'h50, 8'haa, 8'h00}, '{1'b0, 8'h50, 8'h00, 8'h00}};

  always #5 mclk = ~mclk;

  tx_link_controller tx_link_controller_inst (.mclk(mclk), .reset(reset),
    .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .slot(slot), .link_insert(link_insert),
    .link_bit(link_bit), .irq_n(irq_n), .tx_fifo_full(tx_fifo_full));

  framer_model framer_model_inst (.mclk(mclk), .want_link1(want_link1),
    .want_ts(want_ts), .slot(slot), .link_insert(link_insert), .link_bit(link_bit));

  // ========================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 cpu_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    #1 cpu_req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    #1 cpu_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    #1 cpu_req.rd = 1'b0;
    got = cpu_rdata;
  endtask : rd

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // Worked out bit by bit here so that no design function is trusted.
  function automatic logic [15:0] fcs_of(input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n * 8; i++)
      c = (c >> 1) ^ (((c[0] ^ pkt[i / 8][i % 8]) == 1'b1) ? 16'h8408 : 16'h0000);
    return ~c;
  endfunction : fcs_of

  // ========================================
  // Watchdog
  initial begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    results();
  end

  // ========================================
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    #1 reset = 1'b0;
    chk(irq_n, 1);
    chk({link_insert, link_bit, tx_fifo_full}, 3'h2);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a);
        chk(got, rows[i].e);
      end
    end
    cyc(2);
    chk(irq_n, 0);
    rd(8'h38);
    chk(got, 8'h01);
    wr(8'h37, 8'h00);
    cyc(2);
    chk(irq_n, 1);
    // Link disabled: the FIFO must fill to the brim and refuse the last byte.
    wr(8'h36, 8'h04);
    for (int i = 0; i < 18; i++) wr(8'h39, 8'(i));
    rd(8'h38);
    chk(got, 8'h0c);
    rd(8'h38);
    chk(got, 8'h08);
    chk(tx_fifo_full, 1);
    chk(16'(framer_model_inst.n_ins), 0);
    wr(8'h34, 8'h40);
    wr(8'h34, 8'h00);
    rd(8'h38);
    chk(got, 8'h01);
    chk(tx_fifo_full, 0);
    wr(8'h34, 8'hc3);
    wr(8'h34, 8'h83);
    rd(8'h34);
    chk(got, 8'h83);
    foreach (pkt[i]) wr(8'h39, pkt[i]);
    wr(8'h34, 8'h8b);
    rd(8'h34);
    chk(got, 8'h83);
    k = 0;
    while (framer_model_inst.rx.size() < 10 && k < 20000) begin
      cyc(1);
      k++;
    end
    chk(framer_model_inst.rx.size(), 10);
    foreach (pkt[i]) chk(framer_model_inst.rx[i], pkt[i]);
    crc = fcs_of(8);
    chk(framer_model_inst.rx[8], crc[7:0]);
    chk(framer_model_inst.rx[9], crc[15:8]);
    chk(16'(framer_model_inst.bad_pos), 0);
    // Two bytes reach the upper threshold, then the FIFO runs dry without an end mark.
    wr(8'h35, 8'h02);
    for (int i = 0; i < 3; i++) wr(8'h39, 8'ha5);
    k = 0;
    got = 8'h00;
    while (got[1] !== 1'b1 && k < 2000) begin
      rd(8'h38);
      k++;
    end
    chk(got, 8'h03);
    rd(8'h38);
    chk(got, 8'h01);
    chk(framer_model_inst.rx.size(), 10);
    wr(8'h34, 8'h40);
    wr(8'h0d, 8'h00);
    want_link1 = 1'b1;
    wr(8'h34, 8'h01);
    cyc(10);
    n0 = framer_model_inst.n_ins;
    cyc(772);
    chk(16'(framer_model_inst.n_ins - n0), 2);
    chk(16'(framer_model_inst.bad_pos), 0);
    results();
  end
endmodule : hdlc_datalink_transmitter_bench
